// ==== exec_core.sv ====
// Instruction execution unit with Avalon-MM register access
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "exec_consts.svh"

// Summary of operation
// - Skip: one cycle, two when skipping
// - Writing program counter low takes two cycles
// - Paired pre-clears back to back clear flags
// - Repeated single pre-clear has no effect
// - Watchdog clear resets counter and both flags
// - Add with carry into accumulator, four flags
// - Add with carry into memory, four flags
// - Plain add, memory or immediate, four flags
// - AND to accumulator or memory, zero only
// - Call pushes pc plus one, two cycles
// - Byte clear writes zero, flags untouched
// - Bit clear zeroes selected bit only
// - Complement to memory or accumulator, zero
// - Decimal adjust low nibble adds six
// - Decimal adjust high nibble, result to memory
// - Decimal adjust touches carry only
// - Table read current or last page
// - Nibble swap, memory or accumulator variant
// - Zero skip accumulator variant copies byte to accumulator
// - Halt stops, clears watchdog, sets powerdown
// - Jump loads target, two cycles
module exec_core
    import exec_pkg::*;
#(
    parameter int PC_W        = 12,
    parameter int DMEM_DEPTH  = 16,
    parameter int STACK_DEPTH = 8,
    parameter int WDT_CYCLES  = `WDT_CYCLES
) (
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            resetn,
    // Avalon-MM slave
    input  wire logic [7:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    output logic      [31:0]     avs_readdata,
    output logic                 avs_waitrequest,
    // Program memory port
    output logic      [PC_W-1:0] prog_addr,
    input  wire logic [15:0]     prog_data,
    // Power state
    output logic                 clock_stop
);
    localparam int IDX_W = $clog2(DMEM_DEPTH);
    localparam int SP_W  = $clog2(STACK_DEPTH);

    initial begin
        if (PC_W < 9 || PC_W > 16 || DMEM_DEPTH < 2 || DMEM_DEPTH > 47 ||
            STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0 || WDT_CYCLES < 2)
            $error("exec_core: unsupported parameter values");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    run_state_t      state;
    logic [7:0]      acc;
    flags_t          flags;
    logic            powerdown_flag;
    logic            timeout_flag;
    logic [PC_W-1:0] pc;
    logic [7:0]      table_high_latch;
    logic [7:0]      tbl_ptr;
    logic [7:0]      dmem [DMEM_DEPTH];
    logic [PC_W-1:0] stack [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [31:0]     wdt_cnt;
    logic            pre1_last;
    logic            pre2_last;
    logic            tbl_pend;
    logic [IDX_W-1:0] tbl_idx;
    logic            tbl_ok;
    logic            rd_done;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire       in_dmem    = avs_address >= `OFS_DMEM &&
                            avs_address < 8'(`OFS_DMEM + 4 * DMEM_DEPTH);
    wire [7:0] dm_off     = avs_address - `OFS_DMEM;
    wire [IDX_W-1:0] bus_idx = dm_off[IDX_W+1:2];
    wire       is_dummy   = state == DUMMY_ST;
    wire       wr_ok      = avs_write && !is_dummy;
    wire       cmd_wr     = wr_ok && avs_address == `OFS_CMD;
    wire       exec_go    = cmd_wr && state == RUN_ST;
    wire       acc_wr     = wr_ok && avs_address == `OFS_ACC;
    wire       stat_wr    = wr_ok && avs_address == `OFS_STATUS;
    wire       pc_wr      = wr_ok && avs_address == `OFS_PC;
    wire       ptr_wr     = wr_ok && avs_address == `OFS_TBLPTR;
    wire       wake_wr    = wr_ok && avs_address == `OFS_WAKE;
    wire       dmem_bwr   = wr_ok && in_dmem;
    // Every write stalls during a dummy cycle so the table capture owns memory
    assign avs_waitrequest = (avs_read && !rd_done) || (avs_write && is_dummy);

    // ------------------------------------------------------------
    // Operand fetch and arithmetic
    // ------------------------------------------------------------
    cmd_t cmd;
    assign cmd = cmd_t'(avs_writedata[`CMD_BIT_LSB+2:`CMD_OP_LSB]);
    wire [7:0]       m       = cmd.arg[7:0];
    wire             m_pcl   = m == `PCL_ADDR;
    wire             m_ok    = m < 8'(DMEM_DEPTH);
    wire [IDX_W-1:0] m_idx   = m[IDX_W-1:0];
    wire [7:0]       mem_rd  = m_pcl ? pc[7:0] : (m_ok ? dmem[m_idx] : `BYTE_RST);
    wire             use_imm = cmd.op == OP_ADD_AX || cmd.op == OP_AND_AX;
    wire [7:0]       opb     = use_imm ? m : mem_rd;
    wire             cin     = (cmd.op == OP_ADC_AM || cmd.op == OP_ADC_MEM) && flags.c;
    wire [4:0]       sum_lo  = {1'b0, acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    wire [8:0]       sum     = {1'b0, acc} + {1'b0, opb} + {8'h00, cin};
    wire             half_c  = sum_lo[4];
    wire             ovf     = (acc[7] == opb[7]) && (sum[7] != acc[7]);
    wire             lo_adj  = acc[3:0] > 4'h9 || flags.ac;
    wire [8:0]       lo_sum  = {1'b0, acc} + (lo_adj ? 9'h006 : 9'h000);
    // High check follows the low carry so 9a style sums still land in range
    wire             hi_adj  = lo_sum[8:4] > 5'h09 || flags.c;
    wire [8:0]       daa_sum = lo_sum + (hi_adj ? 9'h060 : 9'h000);
    wire [PC_W-1:0]  pc_inc  = pc + PC_W'(1);
    wire [SP_W-1:0]  sp_dec  = sp - SP_W'(1);

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    logic [7:0]      res;
    logic            wr_mem;
    logic            wr_acc;
    logic            set_arith;
    logic            set_z;
    logic            set_c_only;
    logic            skip;
    logic            jump;
    logic [PC_W-1:0] jump_to;
    logic            push;
    logic            pop;
    logic            tbl_req;
    logic            wdt_clr;
    logic            halt_req;
    logic            pre1;
    logic            pre2;

    always_comb begin
        res        = `BYTE_RST;
        wr_mem     = 1'b0;
        wr_acc     = 1'b0;
        set_arith  = 1'b0;
        set_z      = 1'b0;
        set_c_only = 1'b0;
        skip       = 1'b0;
        jump       = 1'b0;
        jump_to    = cmd.arg[PC_W-1:0];
        push       = 1'b0;
        pop        = 1'b0;
        tbl_req    = 1'b0;
        wdt_clr    = 1'b0;
        halt_req   = 1'b0;
        pre1       = 1'b0;
        pre2       = 1'b0;
        unique case (cmd.op)
            OP_ADD_AM, OP_ADD_AX, OP_ADC_AM: begin
                res       = sum[7:0];
                wr_acc    = 1'b1;
                set_arith = 1'b1;
            end
            OP_ADD_TO_MEM, OP_ADC_MEM: begin
                res       = sum[7:0];
                wr_mem    = 1'b1;
                set_arith = 1'b1;
            end
            OP_AND_AM, OP_AND_AX: begin
                res    = acc & opb;
                wr_acc = 1'b1;
                set_z  = 1'b1;
            end
            OP_AND_MEM: begin
                res    = acc & opb;
                wr_mem = 1'b1;
                set_z  = 1'b1;
            end
            OP_CLR_M: begin
                res    = `BYTE_RST;
                wr_mem = 1'b1;
            end
            OP_CLR_BIT: begin
                res    = mem_rd & ~(8'h01 << cmd.bitsel);
                wr_mem = 1'b1;
            end
            OP_CPL_M: begin
                res    = ~mem_rd;
                wr_mem = 1'b1;
                set_z  = 1'b1;
            end
            OP_CPL_ACC: begin
                res    = ~mem_rd;
                wr_acc = 1'b1;
                set_z  = 1'b1;
            end
            OP_DEC_ADJ: begin
                res        = daa_sum[7:0];
                wr_mem     = 1'b1;
                set_c_only = 1'b1;
            end
            OP_SWAP_M: begin
                res    = {mem_rd[3:0], mem_rd[7:4]};
                wr_mem = 1'b1;
            end
            OP_SWAP_ACC: begin
                res    = {mem_rd[3:0], mem_rd[7:4]};
                wr_acc = 1'b1;
            end
            OP_SKIP_Z: skip = mem_rd == `BYTE_RST;
            OP_SKIP_Z_ACC: begin
                res    = mem_rd;
                wr_acc = 1'b1;
                skip   = mem_rd == `BYTE_RST;
            end
            OP_JMP: jump = 1'b1;
            OP_CALL: begin
                jump = 1'b1;
                push = 1'b1;
            end
            OP_RET: begin
                jump    = 1'b1;
                pop     = 1'b1;
                jump_to = stack[sp_dec];
            end
            OP_TBL_CUR, OP_TBL_LAST: tbl_req = 1'b1;
            OP_WDT_CLR:  wdt_clr  = 1'b1;
            OP_WDT_PRE1: pre1     = 1'b1;
            OP_WDT_PRE2: pre2     = 1'b1;
            OP_HALT:     halt_req = 1'b1;
            OP_NOP:      ;
            default:     ;
        endcase
    end

    // A pre-clear counts only right after its partner
    wire pair_hit = (pre1 && pre2_last) || (pre2 && pre1_last);
    wire wdt_hit  = wdt_clr || pair_hit;
    wire pcl_wr   = wr_mem && m_pcl;
    wire two_cyc  = skip || jump || tbl_req || pcl_wr;
    wire [PC_W-1:0] tbl_page = (cmd.op == OP_TBL_LAST) ? {PC_W{1'b1}} : pc;

    logic [PC_W-1:0] next_pc;
    always_comb begin
        next_pc = pc_inc;
        if (skip)
            next_pc = pc + PC_W'(2);
        else if (jump)
            next_pc = jump_to;
        else if (pcl_wr)
            next_pc = {pc[PC_W-1:8], res};
    end

    // ------------------------------------------------------------
    // Sequencing and watchdog
    // ------------------------------------------------------------
    wire wdt_end = wdt_cnt == 32'(WDT_CYCLES - 1);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state <= RUN_ST;
        end else begin
            unique case (state)
                RUN_ST:   if (exec_go && halt_req) state <= HALT_ST;
                          else if (exec_go && two_cyc) state <= DUMMY_ST;
                DUMMY_ST: state <= RUN_ST;
                HALT_ST:  if (wake_wr || wdt_end) state <= RUN_ST;
                default:  state <= RUN_ST;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wdt_cnt        <= 32'h0;
            timeout_flag   <= 1'b0;
            powerdown_flag <= 1'b0;
            pre1_last      <= 1'b0;
            pre2_last      <= 1'b0;
        end else begin
            if (exec_go) begin
                pre1_last <= pre1 && !pair_hit;
                pre2_last <= pre2 && !pair_hit;
            end
            if (exec_go && (wdt_hit || halt_req))
                wdt_cnt <= 32'h0;
            else
                wdt_cnt <= wdt_end ? 32'h0 : wdt_cnt + 32'h1;
            // Timeout wins over a clear in the same cycle
            if (wdt_end)
                timeout_flag <= 1'b1;
            else if (exec_go && (wdt_hit || halt_req))
                timeout_flag <= 1'b0;
            if (exec_go && halt_req)
                powerdown_flag <= 1'b1;
            else if (exec_go && wdt_hit)
                powerdown_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Accumulator, flags, program counter, stack
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            acc   <= `ACC_RST;
            flags <= '0;
        end else if (exec_go) begin
            if (wr_acc)
                acc <= res;
            if (set_arith) begin
                flags.c  <= sum[8];
                flags.ac <= half_c;
                flags.ov <= ovf;
            end
            if (set_arith || set_z)
                flags.z <= res == `BYTE_RST;
            if (set_c_only)
                flags.c <= hi_adj || daa_sum[8];
        end else begin
            if (acc_wr)
                acc <= avs_writedata[7:0];
            if (stat_wr)
                flags <= flags_t'(avs_writedata[`ST_OV:`ST_C]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pc <= '0;
            sp <= '0;
        end else if (exec_go) begin
            pc <= next_pc;
            if (push) begin
                stack[sp] <= pc_inc;
                sp        <= sp + SP_W'(1);
            end
            if (pop)
                sp <= sp_dec;
        end else if (pc_wr) begin
            pc <= avs_writedata[PC_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Data memory and table read
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            table_high_latch <= `BYTE_RST;
            tbl_ptr          <= `BYTE_RST;
            tbl_pend         <= 1'b0;
            tbl_idx          <= '0;
            tbl_ok           <= 1'b0;
            prog_addr        <= '0;
        end else begin
            tbl_pend <= exec_go && tbl_req;
            if (exec_go && tbl_req) begin
                prog_addr <= {tbl_page[PC_W-1:8], tbl_ptr};
                tbl_idx   <= m_idx;
                tbl_ok    <= m_ok;
            end
            if (tbl_pend) begin
                table_high_latch <= prog_data[15:8];
                if (tbl_ok)
                    dmem[tbl_idx] <= prog_data[7:0];
            end
            if (exec_go && wr_mem && m_ok)
                dmem[m_idx] <= res;
            if (dmem_bwr)
                dmem[bus_idx] <= avs_writedata[7:0];
            if (ptr_wr)
                tbl_ptr <= avs_writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (in_dmem)
            rd_mux[7:0] = dmem[bus_idx];
        else if (avs_address == `OFS_ACC)
            rd_mux[7:0] = acc;
        else if (avs_address == `OFS_STATUS) begin
            rd_mux[`ST_OV:`ST_C]       = flags;
            rd_mux[`ST_PDF]            = powerdown_flag;
            rd_mux[`ST_TO]             = timeout_flag;
            rd_mux[`ST_BUSY]           = is_dummy;
            rd_mux[`ST_HALT]           = state == HALT_ST;
            rd_mux[`ST_SP_LSB+:SP_W]   = sp;
        end else if (avs_address == `OFS_PC)
            rd_mux[PC_W-1:0] = pc;
        else if (avs_address == `OFS_TABLE_HIGH_LATCH)
            rd_mux[7:0] = table_high_latch;
        else if (avs_address == `OFS_TBLPTR)
            rd_mux[7:0] = tbl_ptr;
    end

    // Clock stop follows the halt state one edge later than the state itself
    wire next_halt = state == HALT_ST;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rd_done      <= 1'b0;
            avs_readdata <= 32'h0;
            clock_stop   <= 1'b0;
        end else begin
            rd_done    <= avs_read && !rd_done;
            clock_stop <= next_halt;
            if (avs_read && !rd_done)
                avs_readdata <= rd_mux;
        end
    end

endmodule : exec_core

// ==== exec_consts.svh ====
// Offsets, field positions, reset values and timing counts of the execution block
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH
`define OFS_CMD      8'h00
`define OFS_ACC      8'h04
`define OFS_STATUS   8'h08
`define OFS_PC       8'h0c
`define OFS_TABLE_HIGH_LATCH     8'h10
`define OFS_TBLPTR   8'h14
`define OFS_WAKE     8'h18
`define OFS_DMEM     8'h40
`define CMD_OP_LSB   0
`define CMD_ARG_LSB  8
`define CMD_BIT_LSB  20
`define ST_C         0
`define ST_AC        1
`define ST_Z         2
`define ST_OV        3
`define ST_PDF       4
`define ST_TO        5
`define ST_BUSY      8
`define ST_HALT      9
`define ST_SP_LSB    12
`define PCL_ADDR     8'hff
`define ACC_RST      8'h00
`define BYTE_RST     8'h00
`define CLK_MHZ      20
`define WDT_PERIOD_US 1000
`define WDT_CYCLES   (`WDT_PERIOD_US * `CLK_MHZ)
`endif

// ==== exec_pkg.sv ====
// Types shared by the execution block
package exec_pkg;
    typedef enum logic [5:0] {
        OP_NOP     = 6'h00, OP_ADD_AM  = 6'h01, OP_ADD_AX  = 6'h02, OP_ADD_TO_MEM = 6'h03,
        OP_ADC_AM  = 6'h04, OP_ADC_MEM = 6'h05, OP_AND_AM  = 6'h06, OP_AND_AX     = 6'h07,
        OP_AND_MEM = 6'h08, OP_CLR_M   = 6'h09, OP_CLR_BIT = 6'h0a, OP_CPL_M      = 6'h0b,
        OP_CPL_ACC = 6'h0c, OP_DEC_ADJ = 6'h0d, OP_CALL    = 6'h0e, OP_JMP        = 6'h0f,
        OP_RET     = 6'h10, OP_TBL_CUR = 6'h11, OP_TBL_LAST = 6'h12, OP_SWAP_M    = 6'h13,
        OP_SWAP_ACC = 6'h14, OP_SKIP_Z = 6'h15, OP_SKIP_Z_ACC = 6'h16, OP_WDT_CLR = 6'h17,
        OP_WDT_PRE1 = 6'h18, OP_WDT_PRE2 = 6'h19, OP_HALT    = 6'h1a
    } op_t;
    typedef enum logic [2:0] {
        RUN_ST   = 3'b001,
        DUMMY_ST = 3'b010,
        HALT_ST  = 3'b100
    } run_state_t;
    typedef struct packed {
        logic [2:0]  bitsel;
        logic [11:0] arg;
        logic [1:0]  pad;
        op_t         op;
    } cmd_t;
    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_t;
endpackage : exec_pkg

// ==== exec_core_fix.sv ====
// Reserved
`timescale 1ns/1ps

// ==== exec_core_props.sv ====
// Port checker for the execution block
`timescale 1ns/1ps
`include "exec_consts.svh"
module exec_core_props
    import exec_pkg::*;
#(
    parameter int PC_W = 12
) (
    // Clock and reset
    input wire logic            core_clk,
    input wire logic            resetn,
    // Register bus
    input wire logic [7:0]      avs_address,
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic [31:0]     avs_writedata,
    input wire logic [31:0]     avs_readdata,
    input wire logic            avs_waitrequest,
    // Program memory and power
    input wire logic [PC_W-1:0] prog_addr,
    input wire logic [15:0]     prog_data,
    input wire logic            clock_stop
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    wire       cmd_ok  = avs_write && !avs_waitrequest && avs_address == `OFS_CMD;
    wire       wake_ok = avs_write && !avs_waitrequest && avs_address == `OFS_WAKE;
    wire [5:0] opc     = avs_writedata[5:0];
    wire       pcl_arg = avs_writedata[19:8] == 12'h0ff;
    wire       held    = !avs_write || avs_waitrequest;
    wire       free    = !avs_write || !avs_waitrequest;
    wire       halt_cmd = cmd_ok && opc == OP_HALT;
    logic      halt_q;
    // Halted commands are ignored, so the lagging stop flag alone is not enough
    wire       live    = cmd_ok && !clock_stop && !halt_q;

    always_ff @(posedge core_clk) begin
        halt_q <= resetn && halt_cmd;
    end

    jmp_dummy_a:
        assert property (live && opc == OP_JMP |=> held ##1 free) else $error("jump without dummy cycle");
    call_dummy_a:
        assert property (live && opc == OP_CALL |=> held ##1 free) else $error("call without second cycle");
    pcl_write_dummy_a:
        assert property (live && opc == OP_CLR_M && pcl_arg |=> held ##1 free) else $error("pc low write too short");
    byte_clear_single_a:
        assert property (live && opc == OP_CLR_M && !pcl_arg |=> free) else $error("byte clear too long");
    last_page_addr_a:
        assert property (live && opc == OP_TBL_LAST |=> &prog_addr[PC_W-1:8]) else $error("table not on last page");
    halt_stop_a:
        assert property (halt_cmd |-> ##2 clock_stop) else $error("halt did not stop clock");
    wake_run_a:
        assert property (wake_ok && clock_stop |-> ##2 !clock_stop) else $error("wake did not restart clock");
    stop_cause_a:
        assert property ($rose(clock_stop) |-> $past(halt_cmd, 2)) else $error("clock stopped without halt");
endmodule : exec_core_props

bind exec_core exec_core_props #(.PC_W(PC_W)) i_exec_core_props (
    .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr), .prog_data(prog_data),
    .clock_stop(clock_stop)
);

// ==== exec_core_bench.sv ====
// Self-checking bench for the execution block
`timescale 1ns/1ps
`include "exec_consts.svh"
module exec_core_bench
    import exec_pkg::*;
;
    // Short watchdog keeps the run brief
    localparam int WDT = 200;
    localparam logic [31:0] B = 32'hff;
    localparam logic [31:0] F = 32'hf;
    logic        core_clk        = 1'b0;
    logic        resetn          = 1'b0;
    logic [7:0]  avs_address     = 8'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [11:0] prog_addr;
    logic [15:0] prog_data;
    logic        clock_stop;
    logic [31:0] rd;
    int          w;
    int          n_errors        = 0;
    int          samples_checked = 0;
    int          cycles          = 0;

    // Program word is a plain function of its address
    assign prog_data = {4'ha, prog_addr};

    exec_core #(.WDT_CYCLES(WDT)) i_exec_core (
        .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .prog_addr(prog_addr), .prog_data(prog_data),
        .clock_stop(clock_stop)
    );

    always #25 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Leaves write raised so back-to-back writes never touch it twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        w = 0;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            w++;
            @(posedge core_clk);
        end
    endtask : wr

    task automatic look(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        avs_write   <= 1'b0;
        avs_address <= a;
        avs_read    <= 1'b1;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        @(posedge core_clk);
        check(rd & m, e);
    endtask : look

    task automatic idle(input int n);
        avs_write <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask : idle

    task automatic op(input op_t o, input logic [11:0] a = 12'h000, input logic [2:0] b = 3'h0);
        wr(`OFS_CMD, {9'h0, b, a, 2'b00, o});
    endtask : op

    function automatic logic [7:0] dm(input int i);
        return `OFS_DMEM + 8'(4 * i);
    endfunction : dm

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_arith;
        wr(`OFS_STATUS, 32'h0);
        wr(`OFS_ACC, 32'h7f);
        wr(dm(0), 32'h01);
        op(OP_ADD_AM, 12'h000);
        look(`OFS_ACC, B, 32'h80);
        look(`OFS_STATUS, F, 32'ha);
        wr(`OFS_STATUS, 32'h1);
        wr(dm(1), 32'h80);
        op(OP_ADC_MEM, 12'h001);
        look(dm(1), B, 32'h01);
        look(`OFS_ACC, B, 32'h80);
        look(`OFS_STATUS, F, 32'h9);
        wr(`OFS_ACC, 32'h0e);
        op(OP_ADC_AM, 12'h000);
        look(`OFS_ACC, B, 32'h10);
        look(`OFS_STATUS, F, 32'h2);
        op(OP_ADD_TO_MEM, 12'h000);
        look(dm(0), B, 32'h11);
        wr(`OFS_STATUS, 32'h1);
        op(OP_ADD_AX, 12'h0f0);
        look(`OFS_ACC, B, 32'h00);
        look(`OFS_STATUS, F, 32'h5);
        $display("arith done");
    endtask : t_arith

    task automatic t_logic;
        wr(`OFS_STATUS, 32'hb);
        wr(`OFS_ACC, 32'h0f);
        op(OP_AND_AX, 12'h0f0);
        look(`OFS_ACC, B, 32'h00);
        look(`OFS_STATUS, F, 32'hf);
        wr(dm(2), 32'h5a);
        op(OP_CPL_ACC, 12'h002);
        look(`OFS_ACC, B, 32'ha5);
        look(dm(2), B, 32'h5a);
        look(`OFS_STATUS, F, 32'hb);
        op(OP_CPL_M, 12'h002);
        look(dm(2), B, 32'ha5);
        op(OP_CLR_M, 12'h002);
        look(dm(2), B, 32'h00);
        look(`OFS_STATUS, F, 32'hb);
        wr(dm(3), 32'hff);
        op(OP_CLR_BIT, 12'h003, 3'h5);
        look(dm(3), B, 32'hdf);
        op(OP_AND_MEM, 12'h003);
        look(dm(3), B, 32'h85);
        op(OP_AND_AM, 12'h003);
        look(`OFS_ACC, B, 32'h85);
        $display("logic done");
    endtask : t_logic

    task automatic t_daa;
        wr(`OFS_STATUS, 32'h0);
        wr(`OFS_ACC, 32'h9a);
        op(OP_DEC_ADJ, 12'h004);
        look(dm(4), B, 32'h00);
        look(`OFS_STATUS, F, 32'h1);
        wr(`OFS_STATUS, 32'h2);
        wr(`OFS_ACC, 32'h12);
        op(OP_DEC_ADJ, 12'h004);
        look(dm(4), B, 32'h18);
        look(`OFS_STATUS, F, 32'h2);
        $display("decimal done");
    endtask : t_daa

    task automatic t_swap;
        wr(dm(5), 32'h3c);
        op(OP_SWAP_ACC, 12'h005);
        look(`OFS_ACC, B, 32'hc3);
        look(dm(5), B, 32'h3c);
        op(OP_SWAP_M, 12'h005);
        look(dm(5), B, 32'hc3);
        look(8'h3c, 32'hffffffff, 32'h0);
        $display("swap done");
    endtask : t_swap

    task automatic t_flow;
        wr(`OFS_PC, 32'h010);
        op(OP_CALL, 12'h123);
        look(`OFS_PC, 32'hfff, 32'h123);
        op(OP_RET);
        look(`OFS_PC, 32'hfff, 32'h011);
        op(OP_JMP, 12'h200);
        op(OP_NOP);
        check(32'(w), 32'h1);
        wr(dm(6), 32'h00);
        wr(`OFS_PC, 32'h200);
        op(OP_SKIP_Z_ACC, 12'h006);
        look(`OFS_PC, 32'hfff, 32'h202);
        look(`OFS_ACC, B, 32'h00);
        op(OP_SKIP_Z_ACC, 12'h006);
        op(OP_NOP);
        check(32'(w), 32'h1);
        wr(dm(6), 32'h07);
        op(OP_SKIP_Z, 12'h006);
        op(OP_NOP);
        check(32'(w), 32'h0);
        op(OP_CLR_M, 12'h0ff);
        op(OP_NOP);
        check(32'(w), 32'h1);
        wr(`OFS_TBLPTR, 32'h34);
        wr(`OFS_PC, 32'h500);
        op(OP_TBL_CUR, 12'h007);
        idle(1);
        check({20'h0, prog_addr}, 32'h534);
        look(dm(7), B, 32'h34);
        look(`OFS_TABLE_HIGH_LATCH, B, 32'ha5);
        op(OP_TBL_LAST, 12'h008);
        idle(1);
        look(`OFS_TABLE_HIGH_LATCH, B, 32'haf);
        $display("flow done");
    endtask : t_flow

    task automatic t_wdt;
        idle(WDT + 5);
        op(OP_HALT);
        idle(2);
        check({31'h0, clock_stop}, 32'h1);
        look(`OFS_STATUS, 32'h230, 32'h210);
        wr(`OFS_WAKE, 32'h1);
        idle(2);
        check({31'h0, clock_stop}, 32'h0);
        op(OP_WDT_CLR);
        look(`OFS_STATUS, 32'h30, 32'h0);
        idle(WDT + 5);
        look(`OFS_STATUS, 32'h30, 32'h20);
        op(OP_WDT_PRE1);
        op(OP_WDT_PRE1);
        look(`OFS_STATUS, 32'h30, 32'h20);
        op(OP_NOP);
        op(OP_WDT_PRE2);
        look(`OFS_STATUS, 32'h30, 32'h20);
        op(OP_NOP);
        op(OP_WDT_PRE1);
        op(OP_WDT_PRE2);
        look(`OFS_STATUS, 32'h30, 32'h0);
        $display("watchdog done");
    endtask : t_wdt

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_arith();
        t_logic();
        t_daa();
        t_swap();
        t_flow();
        t_wdt();
        idle(2);
        end_sim();
    end
endmodule : exec_core_bench
